// [rcs_switcher.sv]
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/1ps

// Notes on behaviour
// - Switching and fail-safe monitor only work when the config bit is zero.
// - With switching off, new source is ignored; status shows configured source.
// - With switching off, request bit reads zero and writes do nothing.
// - Current source is read-only at bits 13:12.
// - High byte writes need 0x78 then 0x9A first.
// - Low byte writes need 0x46 then 0x57 first.
// - New source select is writable at bits 9:8.
// - Setting request bit 0 starts a switch.
// - A request for the current source clears itself and is dropped.
// - A real switch clears lock bit 5 and clock-fail bit 3.
// - Target is enabled; wait for its startup timer and, for primary with PLL, also PLL lock.
// - Count ten target clock cycles, then move the clock mux.
// - On completion clear request and copy new into current source.
// - Old source turns off unless watchdog, monitor or keep-on hold it.
// - The old clock keeps running the processor throughout.
// - A missing target makes the switch wait forever, request stays set.
// - Clearing the request aborts, stopping timer and PLL.
// - Sleep during a switch aborts it, keeps old clock, clears request.
// - Four sources: primary, 32 kHz secondary, fast RC, slow RC.
// - Codes: 00 secondary, 01 fast RC, 10 slow RC.
module rcs_switcher
    import rcs_pkg::*;
(
    // Clock and reset.
    input wire logic CLK,
    input wire logic ARST_N,
    // APB slave.
    input wire rcs_apb_req_t APB_REQ,
    output rcs_apb_rsp_t APB_RSP,
    // Configuration and system inputs.
    input wire logic SWITCH_MONITOR_CFG_N,
    input wire logic [1:0] INITIAL_SOURCE_CFG,
    input wire logic PRIMARY_USES_PLL,
    input wire logic WATCHDOG_EN,
    input wire logic SLEEP_ENTRY,
    // Oscillator handshake.
    input wire logic [3:0] OSC_READY,
    input wire logic PLL_LOCKED,
    input wire logic [3:0] OSC_CLK_LVL,
    // Clock control outputs.
    output rcs_clk_out_t CLK_OUT
);

    rcs_state_t s_reg;
    rcs_state_t s_next;

    logic sw_en;
    logic acc;
    logic wr_ctl;
    logic rd_ok;
    logic [7:0] wb_hi;
    logic [7:0] wb_lo;
    logic tgt_ready;
    logic tgt_edge;
    logic [31:0] rd_word;

    function automatic rcs_lock_t lock_step(rcs_lock_t cur, logic [7:0] d,
                                            logic [7:0] k1, logic [7:0] k2);
        rcs_lock_t r;
        r = RCS_LK_NONE;
        if (d == k1)
        begin
            r = RCS_LK_ONE;
        end
        if ((cur == RCS_LK_ONE) && (d == k2))
        begin
            r = RCS_LK_OPEN;
        end
        return r;
    endfunction

    function automatic logic [3:0] onehot(logic [1:0] code);
        return 4'h1 << code;
    endfunction

    assign sw_en = ~SWITCH_MONITOR_CFG_N;
    assign acc = APB_REQ.psel & APB_REQ.penable;
    assign wr_ctl = acc & APB_REQ.pwrite & (APB_REQ.paddr == RCS_ADDR_CONTROL);
    assign rd_ok = (APB_REQ.paddr == RCS_ADDR_CONTROL) | (APB_REQ.paddr == RCS_ADDR_OSC);
    assign wb_hi = APB_REQ.pwdata[15:8];
    assign wb_lo = APB_REQ.pwdata[7:0];
    // Primary may need PLL lock; others need their own ready (timer expiry).
    assign tgt_ready = OSC_READY[s_reg.new_src]
        & ((s_reg.new_src != RCS_SRC_PRI) | ~PRIMARY_USES_PLL | PLL_LOCKED);
    assign tgt_edge = OSC_CLK_LVL[s_reg.new_src] & ~s_reg.tgt_div_d;

    always_comb
    begin
        rd_word = RCS_READ_ZERO;
        if (APB_REQ.paddr == RCS_ADDR_CONTROL)
        begin
            rd_word[RCS_CUR_LO +: 2] = s_reg.cur_src;
            rd_word[RCS_NEW_LO +: 2] = s_reg.new_src;
            rd_word[RCS_BIT_LOCK] = s_reg.lock_flag;
            rd_word[RCS_BIT_FAIL] = s_reg.fail_flag;
            rd_word[RCS_BIT_KEEP] = s_reg.keep_on;
            rd_word[RCS_BIT_REQ] = s_reg.req;
        end
        else if (APB_REQ.paddr == RCS_ADDR_OSC)
        begin
            rd_word[3:0] = s_reg.osc_en;
        end
    end

    always_comb
    begin
        s_next = s_reg;
        s_next.rsp.pready = 1'b1;
        s_next.tgt_div_d = OSC_CLK_LVL[s_reg.new_src];
        if (PLL_LOCKED)
        begin
            s_next.lock_flag = 1'b1;
        end
        if (!s_reg.init_done)
        begin
            s_next.init_done = 1'b1;
            s_next.cur_src = INITIAL_SOURCE_CFG;
            s_next.old_src = INITIAL_SOURCE_CFG;
            s_next.osc_en = onehot(INITIAL_SOURCE_CFG);
        end
        // Read data and error are registered in the setup cycle so they stand in the access phase.
        if (APB_REQ.psel && !APB_REQ.penable)
        begin
            s_next.rsp.prdata = rd_word;
            s_next.rsp.pslverr = ~rd_ok;
        end
        if (wr_ctl)
        begin
            // Each byte write either advances its key state or, when open, is accepted.
            if (s_reg.hi_lock == RCS_LK_OPEN)
            begin
                s_next.hi_lock = RCS_LK_NONE;
                s_next.new_src = wb_hi[RCS_NEW_LO - 8 +: 2];
            end
            else
            begin
                s_next.hi_lock = lock_step(s_reg.hi_lock, wb_hi, RCS_HI_KEY1, RCS_HI_KEY2);
            end
            if (s_reg.lo_lock == RCS_LK_OPEN)
            begin
                s_next.lo_lock = RCS_LK_NONE;
                s_next.keep_on = wb_lo[RCS_BIT_KEEP];
                s_next.req = wb_lo[RCS_BIT_REQ] & sw_en;
            end
            else
            begin
                s_next.lo_lock = lock_step(s_reg.lo_lock, wb_lo, RCS_LO_KEY1, RCS_LO_KEY2);
            end
        end
        unique case (s_reg.phase)
            RCS_IDLE:
            begin
                if (s_reg.req && sw_en)
                begin
                    s_next.phase = RCS_START;
                end
            end
            RCS_START:
            begin
                if (s_reg.new_src == s_reg.cur_src)
                begin
                    s_next.req = 1'b0;
                    s_next.phase = RCS_IDLE;
                end
                else
                begin
                    s_next.lock_flag = 1'b0;
                    s_next.fail_flag = 1'b0;
                    s_next.osc_en[s_reg.new_src] = 1'b1;
                    s_next.old_src = s_reg.cur_src;
                    s_next.phase = RCS_WAIT;
                end
            end
            RCS_WAIT:
            begin
                s_next.sync_cnt = '0;
                if (tgt_ready)
                begin
                    s_next.phase = RCS_SYNC;
                end
            end
            RCS_SYNC:
            begin
                if (tgt_edge)
                begin
                    s_next.sync_cnt = s_reg.sync_cnt + 4'h1;
                    if (s_reg.sync_cnt == 4'(RCS_SYNC_CYCLES - 1))
                    begin
                        s_next.phase = RCS_SWAP;
                    end
                end
            end
            RCS_SWAP:
            begin
                s_next.cur_src = s_reg.new_src;
                s_next.req = 1'b0;
                s_next.osc_en = onehot(s_reg.new_src);
                if (s_reg.old_src == RCS_SRC_SLOW && (WATCHDOG_EN || sw_en))
                begin
                    s_next.osc_en[RCS_SRC_SLOW] = 1'b1;
                end
                s_next.phase = RCS_IDLE;
            end
        endcase
        if (s_reg.keep_on)
        begin
            s_next.osc_en[RCS_SRC_SEC] = 1'b1;
        end
        if (WATCHDOG_EN || sw_en)
        begin
            s_next.osc_en[RCS_SRC_SLOW] = 1'b1;
        end
        // Abort by software clear or by Sleep entry; old source stays selected.
        if (s_reg.phase != RCS_IDLE && s_reg.phase != RCS_SWAP
            && (!s_next.req || SLEEP_ENTRY))
        begin
            s_next.req = 1'b0;
            s_next.phase = RCS_IDLE;
            s_next.sync_cnt = '0;
            s_next.osc_en = onehot(s_reg.cur_src) | (s_next.osc_en & onehot(RCS_SRC_SLOW))
                | (s_reg.keep_on ? onehot(RCS_SRC_SEC) : 4'h0);
        end
        if (!sw_en)
        begin
            s_next.req = 1'b0;
            s_next.phase = RCS_IDLE;
            s_next.cur_src = INITIAL_SOURCE_CFG;
            s_next.osc_en[INITIAL_SOURCE_CFG] = 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // The mux moves in the swap step, or to the configured source when switching is off; until then the old source runs on.
    assign APB_RSP = s_reg.rsp;
    assign CLK_OUT.osc_en = s_reg.osc_en;
    assign CLK_OUT.sys_sel = s_reg.cur_src;
    assign CLK_OUT.sys_sel_valid = s_reg.init_done;

    property p_disabled_no_req;
        @(posedge CLK) disable iff (!ARST_N) SWITCH_MONITOR_CFG_N |=> !s_reg.req;
    endproperty
    a_disabled_no_req: assert property (p_disabled_no_req)
        else $error("Request set while switching disabled.");

    property p_redundant;
        @(posedge CLK) disable iff (!ARST_N)
        (s_reg.phase == RCS_START && s_reg.new_src == s_reg.cur_src && !SLEEP_ENTRY && sw_en)
        |=> (!s_reg.req && s_reg.phase == RCS_IDLE);
    endproperty
    a_redundant: assert property (p_redundant)
        else $error("Redundant request not dropped.");

    property p_clear_flags;
        @(posedge CLK) disable iff (!ARST_N)
        (s_reg.phase == RCS_START && s_reg.new_src != s_reg.cur_src && s_next.phase == RCS_WAIT)
        |=> (!s_reg.fail_flag && !s_reg.lock_flag);
    endproperty
    a_clear_flags: assert property (p_clear_flags)
        else $error("Status flags not cleared at switch start.");

    property p_target_on;
        @(posedge CLK) disable iff (!ARST_N)
        (s_reg.phase == RCS_START && s_next.phase == RCS_WAIT)
        |=> s_reg.osc_en[$past(s_reg.new_src)];
    endproperty
    a_target_on: assert property (p_target_on)
        else $error("Target oscillator not enabled at switch start.");

    property p_sw_abort;
        @(posedge CLK) disable iff (!ARST_N)
        (s_reg.phase inside {RCS_START, RCS_WAIT, RCS_SYNC} && wr_ctl
            && s_reg.lo_lock == RCS_LK_OPEN && !wb_lo[RCS_BIT_REQ])
        |=> (!s_reg.req && s_reg.phase == RCS_IDLE);
    endproperty
    a_sw_abort: assert property (p_sw_abort)
        else $error("Clearing the request did not abort the switch.");

    property p_old_off;
        @(posedge CLK) disable iff (!ARST_N)
        (s_reg.phase == RCS_SWAP && sw_en && s_reg.old_src != RCS_SRC_SLOW
            && !(s_reg.old_src == RCS_SRC_SEC && s_reg.keep_on))
        |=> !CLK_OUT.osc_en[$past(s_reg.old_src)];
    endproperty
    a_old_off: assert property (p_old_off)
        else $error("Old source left running after the swap.");

    property p_keep_on;
        @(posedge CLK) disable iff (!ARST_N) s_reg.keep_on |=> CLK_OUT.osc_en[RCS_SRC_SEC];
    endproperty
    a_keep_on: assert property (p_keep_on)
        else $error("Secondary stopped although keep-on is set.");

    property p_disabled_status;
        @(posedge CLK) disable iff (!ARST_N)
        !sw_en |=> s_reg.cur_src == $past(INITIAL_SOURCE_CFG);
    endproperty
    a_disabled_status: assert property (p_disabled_status)
        else $error("Status does not follow the configured source.");

    property p_swap_done;
        @(posedge CLK) disable iff (!ARST_N)
        (s_reg.phase == RCS_SWAP && sw_en)
        |=> (!s_reg.req && s_reg.cur_src == $past(s_reg.new_src));
    endproperty
    a_swap_done: assert property (p_swap_done)
        else $error("Swap did not update status.");

    property p_cur_stable;
        @(posedge CLK) disable iff (!ARST_N)
        (s_reg.phase inside {RCS_START, RCS_WAIT, RCS_SYNC} && sw_en) |=> $stable(CLK_OUT.sys_sel);
    endproperty
    a_cur_stable: assert property (p_cur_stable)
        else $error("Clock moved before the swap.");

    property p_sleep_abort;
        @(posedge CLK) disable iff (!ARST_N)
        (SLEEP_ENTRY && s_reg.phase inside {RCS_START, RCS_WAIT, RCS_SYNC})
        |=> (!s_reg.req && s_reg.phase == RCS_IDLE);
    endproperty
    a_sleep_abort: assert property (p_sleep_abort)
        else $error("Sleep did not abort the switch.");

    property p_sync_count;
        @(posedge CLK) disable iff (!ARST_N)
        (s_reg.phase == RCS_SWAP) |-> $past(s_reg.sync_cnt) == 4'(RCS_SYNC_CYCLES - 1);
    endproperty
    a_sync_count: assert property (p_sync_count)
        else $error("Swap without ten target cycles.");

    property p_wait_holds;
        @(posedge CLK) disable iff (!ARST_N)
        (s_reg.phase == RCS_WAIT && !tgt_ready && !SLEEP_ENTRY && s_reg.req && !wr_ctl && sw_en)
        |=> s_reg.phase == RCS_WAIT && s_reg.req;
    endproperty
    a_wait_holds: assert property (p_wait_holds)
        else $error("Wait ended without a ready target.");

    c_swap: cover property (@(posedge CLK) disable iff (!ARST_N) s_reg.phase == RCS_SWAP);
    c_redundant: cover property (@(posedge CLK) disable iff (!ARST_N)
        s_reg.phase == RCS_START && s_reg.new_src == s_reg.cur_src);
    c_sleep: cover property (@(posedge CLK) disable iff (!ARST_N)
        SLEEP_ENTRY && s_reg.phase == RCS_WAIT);
    c_sw_abort: cover property (@(posedge CLK) disable iff (!ARST_N)
        s_reg.phase == RCS_WAIT && wr_ctl && s_reg.lo_lock == RCS_LK_OPEN);
    c_keep_swap: cover property (@(posedge CLK) disable iff (!ARST_N)
        s_reg.phase == RCS_SWAP && s_reg.keep_on);

endmodule

// [rcs_pkg.sv]
package rcs_pkg;

    // Register map. The control register is one aligned word.
    localparam logic [11:0] RCS_ADDR_CONTROL = 12'h000;
    localparam logic [11:0] RCS_ADDR_OSC = 12'h004;

    // Field positions in the control register.
    localparam int RCS_BIT_REQ = 0;
    localparam int RCS_BIT_KEEP = 1;
    localparam int RCS_BIT_FAIL = 3;
    localparam int RCS_BIT_LOCK = 5;
    localparam int RCS_NEW_LO = 8;
    localparam int RCS_CUR_LO = 12;

    // Unlock codes for the two bytes.
    localparam logic [7:0] RCS_HI_KEY1 = 8'h78;
    localparam logic [7:0] RCS_HI_KEY2 = 8'h9a;
    localparam logic [7:0] RCS_LO_KEY1 = 8'h46;
    localparam logic [7:0] RCS_LO_KEY2 = 8'h57;

    // Source codes.
    localparam logic [1:0] RCS_SRC_SEC = 2'h0;
    localparam logic [1:0] RCS_SRC_FAST = 2'h1;
    localparam logic [1:0] RCS_SRC_SLOW = 2'h2;
    localparam logic [1:0] RCS_SRC_PRI = 2'h3;

    // Synchronisation cycles of the target clock.
    localparam int RCS_SYNC_CYCLES = 10;
    localparam logic [31:0] RCS_READ_ZERO = 32'h0000_0000;

    typedef enum logic [2:0] {
        RCS_IDLE = 3'b000,
        RCS_START = 3'b001,
        RCS_WAIT = 3'b010,
        RCS_SYNC = 3'b011,
        RCS_SWAP = 3'b100
    } rcs_phase_t;

    // Unlock progress for one byte.
    typedef enum logic [1:0] {
        RCS_LK_NONE = 2'b00,
        RCS_LK_ONE = 2'b01,
        RCS_LK_OPEN = 2'b10
    } rcs_lock_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } rcs_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } rcs_apb_rsp_t;

    // Clock outputs: oscillator enables, one bit per source code, and the mux select with its valid bit.
    typedef struct packed {
        logic [3:0] osc_en;
        logic sys_sel_valid;
        logic [1:0] sys_sel;
    } rcs_clk_out_t;

    typedef struct packed {
        rcs_phase_t phase;
        rcs_lock_t hi_lock;
        rcs_lock_t lo_lock;
        logic [1:0] cur_src;
        logic [1:0] new_src;
        logic [1:0] old_src;
        logic req;
        logic keep_on;
        logic lock_flag;
        logic fail_flag;
        logic [3:0] sync_cnt;
        logic [3:0] osc_en;
        logic tgt_div_d;
        logic init_done;
        rcs_apb_rsp_t rsp;
    } rcs_state_t;

endpackage

// [rcs_switcher_bench.sv]
`timescale 1ns/1ps
module rcs_switcher_bench;
    import rcs_pkg::*;
    logic clk;
    logic arst_n;
    rcs_apb_req_t apb_req;
    rcs_apb_rsp_t apb_rsp;
    logic cfg_n;
    logic [1:0] init_cfg;
    logic pri_pll;
    logic wdog_en;
    logic sleep;
    logic [3:0] ready;
    logic pll_locked;
    logic [3:0] lvl;
    rcs_clk_out_t clk_out;
    logic [31:0] rdata;
    logic rerr;
    int fails;
    int checked;

    rcs_switcher uut (
        .CLK(clk),
        .ARST_N(arst_n),
        .APB_REQ(apb_req),
        .APB_RSP(apb_rsp),
        .SWITCH_MONITOR_CFG_N(cfg_n),
        .INITIAL_SOURCE_CFG(init_cfg),
        .PRIMARY_USES_PLL(pri_pll),
        .WATCHDOG_EN(wdog_en),
        .SLEEP_ENTRY(sleep),
        .OSC_READY(ready),
        .PLL_LOCKED(pll_locked),
        .OSC_CLK_LVL(lvl),
        .CLK_OUT(clk_out)
    );

    always #5 clk = ~clk;

    task complete_run;
        $display("Counts: %0d checks, %0d failures", checked, fails);
        if (fails == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One APB transfer; read data and error are taken at the edge that completes it.
    task apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
        @(posedge clk);
        apb_req.psel <= 1'b1;
        apb_req.penable <= 1'b0;
        apb_req.pwrite <= wr;
        apb_req.paddr <= addr;
        apb_req.pwdata <= wd;
        @(posedge clk);
        apb_req.penable <= 1'b1;
        @(posedge clk);
        while (apb_rsp.pready !== 1'b1)
        begin
            @(posedge clk);
        end
        rdata = apb_rsp.prdata;
        rerr = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask

    task ctl(input logic [1:0] src, input logic keep, input logic req);
        apb(1'b1, RCS_ADDR_CONTROL, {16'h0, RCS_HI_KEY1, RCS_LO_KEY1});
        apb(1'b1, RCS_ADDR_CONTROL, {16'h0, RCS_HI_KEY2, RCS_LO_KEY2});
        apb(1'b1, RCS_ADDR_CONTROL, {22'h0, src, 6'h0, keep, req});
    endtask

    // Reads the control word and compares request, current source and the clock mux.
    task expect_state(input logic rq, input logic [1:0] cur, input string what);
        apb(1'b0, RCS_ADDR_CONTROL, 32'h0);
        chk({31'h0, rdata[0]}, {31'h0, rq}, {what, " request"});
        chk({30'h0, rdata[13:12]}, {30'h0, cur}, {what, " current source"});
        chk({30'h0, clk_out.sys_sel}, {30'h0, cur}, {what, " clock mux"});
    endtask

    task expect_osc(input logic [3:0] en, input string what);
        apb(1'b0, RCS_ADDR_OSC, 32'h0);
        chk({28'h0, rdata[3:0]}, {28'h0, en}, {what, " enable readback"});
        chk({28'h0, clk_out.osc_en}, {28'h0, en}, {what, " enable pins"});
    endtask

    task edges(input int b, input int n);
        repeat (n)
        begin
            @(posedge clk);
            lvl[b] <= 1'b1;
            @(posedge clk);
            lvl[b] <= 1'b0;
        end
        repeat (6) @(posedge clk);
    endtask

    task set_ready(input int b);
        @(posedge clk);
        ready[b] <= 1'b1;
        repeat (3) @(posedge clk);
    endtask

    initial
    begin
        #100000;
        fails++;
        complete_run();
    end

    initial
    begin
        clk = 1'b0;
        arst_n = 1'b0;
        apb_req = '0;
        cfg_n = 1'b0;
        init_cfg = RCS_SRC_FAST;
        pri_pll = 1'b1;
        wdog_en = 1'b0;
        sleep = 1'b0;
        ready = 4'h6;
        pll_locked = 1'b1;
        lvl = 4'h0;
        fails = 0;
        checked = 0;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        expect_state(1'b0, RCS_SRC_FAST, "after reset");
        chk({31'h0, rdata[5]}, 32'h1, "lock flag before switch");
        expect_osc(4'b0110, "after reset");
        apb(1'b0, 12'h008, 32'h0);
        chk({31'h0, rerr}, 32'h1, "unmapped error");
        chk(rdata, 32'h0, "unmapped data");
        // Writes without a full key pair in a row are ignored.
        apb(1'b1, RCS_ADDR_CONTROL, {16'h0, 6'h0, RCS_SRC_SLOW, 8'h01});
        apb(1'b1, RCS_ADDR_CONTROL, {16'h0, RCS_HI_KEY2, RCS_LO_KEY2});
        apb(1'b1, RCS_ADDR_CONTROL, {16'h0, 6'h0, RCS_SRC_SLOW, 8'h01});
        apb(1'b1, RCS_ADDR_CONTROL, {16'h0, RCS_HI_KEY1, RCS_LO_KEY1});
        apb(1'b1, RCS_ADDR_CONTROL, {16'h0, 6'h0, RCS_SRC_SLOW, 8'h01});
        expect_state(1'b0, RCS_SRC_FAST, "locked writes");
        // Redundant request clears itself.
        ctl(RCS_SRC_FAST, 1'b0, 1'b1);
        repeat (4) @(posedge clk);
        expect_state(1'b0, RCS_SRC_FAST, "redundant");
        chk({30'h0, rdata[9:8]}, {30'h0, RCS_SRC_FAST}, "new source field");
        // Fast to primary with no crystal and no lock; the secondary is never a target.
        @(posedge clk);
        pll_locked <= 1'b0;
        ctl(RCS_SRC_PRI, 1'b1, 1'b1);
        repeat (20) @(posedge clk);
        expect_state(1'b1, RCS_SRC_FAST, "target absent");
        chk({31'h0, rdata[5]}, 32'h0, "lock flag cleared");
        chk({31'h0, rdata[3]}, 32'h0, "fail flag cleared");
        expect_osc(4'b1111, "target started");
        ctl(RCS_SRC_PRI, 1'b1, 1'b0);
        repeat (4) @(posedge clk);
        expect_state(1'b0, RCS_SRC_FAST, "software abort");
        expect_osc(4'b0111, "primary stopped");
        // Same request, aborted by sleep entry.
        ctl(RCS_SRC_PRI, 1'b1, 1'b1);
        repeat (10) @(posedge clk);
        sleep <= 1'b1;
        @(posedge clk);
        sleep <= 1'b0;
        repeat (4) @(posedge clk);
        expect_state(1'b0, RCS_SRC_FAST, "sleep abort");
        expect_osc(4'b0111, "sleep abort");
        // Crystal ready but no lock: target edges are not counted yet.
        set_ready(3);
        ctl(RCS_SRC_PRI, 1'b1, 1'b1);
        edges(3, 12);
        expect_state(1'b1, RCS_SRC_FAST, "waiting for lock");
        chk({31'h0, rdata[5]}, 32'h0, "lock still clear");
        @(posedge clk);
        pll_locked <= 1'b1;
        repeat (4) @(posedge clk);
        edges(3, 9);
        expect_state(1'b1, RCS_SRC_FAST, "nine target cycles");
        edges(3, 1);
        expect_state(1'b0, RCS_SRC_PRI, "ten target cycles");
        chk({31'h0, rdata[5]}, 32'h1, "lock flag set");
        expect_osc(4'b1101, "fast off, secondary kept on");
        // Primary to slow RC without keep-on: primary and secondary go off.
        ctl(RCS_SRC_SLOW, 1'b0, 1'b1);
        repeat (4) @(posedge clk);
        edges(2, 10);
        expect_state(1'b0, RCS_SRC_SLOW, "slow reached");
        expect_osc(4'b0100, "old sources off");
        // Switching disabled by configuration.
        @(posedge clk);
        cfg_n <= 1'b1;
        init_cfg <= RCS_SRC_FAST;
        repeat (4) @(posedge clk);
        expect_state(1'b0, RCS_SRC_FAST, "disabled status");
        ctl(RCS_SRC_SEC, 1'b0, 1'b1);
        repeat (20) @(posedge clk);
        expect_state(1'b0, RCS_SRC_FAST, "disabled request");
        complete_run();
    end
endmodule
